// ==== hw/fbi_host_ctrl.sv ====
// host controller driving an asynchronous parallel flash bus
`timescale 1ns/1ps
`default_nettype none
module fbi_host_ctrl
  import fbi_pkg::*;
(
  input  wire logic               mclk,
  input  wire logic               resetn,
  input  wire logic               reqValid,
  input  wire logic               reqWrite,
  input  wire logic [BADDR_W-1:0] reqAddr,
  input  wire logic [DATA_W-1:0]  reqWdata,
  input  wire logic               byteMode,
  input  wire logic               protectOn,
  output var  logic               reqReady,
  output var  logic               rspValid,
  output var  logic [DATA_W-1:0]  rspData,
  output var  logic               deviceBusy,
  output var  logic               flashCeN,
  output var  logic               flashOeN,
  output var  logic               flashWeN,
  output var  logic               flashRstN,
  output var  logic               flashWpN,
  output var  logic               flashByteN,
  output var  logic [ADDR_W-1:0]  flashAddr,
  input  wire logic [DATA_W-1:0]  flashDqIn,
  output var  logic [DATA_W-1:0]  flashDqOut,
  output var  logic [DATA_W-1:0]  flashDqOeN,
  input  wire logic               completionFlagNIn
);

  ////////////////////////////////////////////////////////////////////////////
  // pin address mapping

  // byte mode puts the byte-select bit on the top data pin
  function automatic logic [ADDR_W-1:0] pin_addr(input logic [BADDR_W-1:0] a,
                                                 input logic                byteSel);
    return byteSel ? a[BADDR_W-1:1] : a[ADDR_W-1:0];
  endfunction : pin_addr

  ////////////////////////////////////////////////////////////////////////////
  // synchronisers on pin inputs

  logic [DATA_W-1:0] dqSync;
  logic              flagNSync;

  fbi_sync #(.W(DATA_W)) uDqSync (
    .mclk   (mclk),
    .resetn (resetn),
    .din    (flashDqIn),
    .dout   (dqSync)
  );

  fbi_sync #(.W(1)) uFlagSync (
    .mclk   (mclk),
    .resetn (resetn),
    .din    (completionFlagNIn),
    .dout   (flagNSync)
  );

  ////////////////////////////////////////////////////////////////////////////
  // state and pin registers

  fbi_state_t        state_r,    state_nxt;
  logic [CNT_W-1:0]  cnt_r,      cnt_nxt;
  logic              byteSel_r,  byteSel_nxt;
  logic              ready_r,    ready_nxt;
  logic              rspV_r,     rspV_nxt;
  logic [DATA_W-1:0] rspD_r,     rspD_nxt;
  logic              ceN_r,      ceN_nxt;
  logic              oeN_r,      oeN_nxt;
  logic              weN_r,      weN_nxt;
  logic              rstN_r,     rstN_nxt;
  logic [ADDR_W-1:0] addr_r,     addr_nxt;
  logic [DATA_W-1:0] dqOut_r,    dqOut_nxt;
  logic [DATA_W-1:0] dqOeN_r,    dqOeN_nxt;
  logic              wpN_r;
  logic              busy_r;
  logic              byteN_r;

  // decode of the request port
  wire               take     = ready_r & reqValid;
  wire               cntZero  = (cnt_r == '0);
  wire [DATA_W-1:0]  rdWord   = byteSel_r ? {8'h00, dqSync[7:0]} : dqSync;
  // top pin driven as address LSB in byte mode; low bits only driven on write
  wire [DATA_W-1:0]  wrOeN    = byteSel_r ? 16'h7f00 : 16'h0000;
  wire [DATA_W-1:0]  idleOeN  = byteSel_r ? 16'h7fff : 16'hffff;
  wire [DATA_W-1:0]  wrData   = byteSel_r ? {reqAddr[0], 7'h00, reqWdata[7:0]} : reqWdata;
  wire [DATA_W-1:0]  rdData   = byteSel_r ? {reqAddr[0], 15'h0000} : 16'h0000;

  ////////////////////////////////////////////////////////////////////////////
  // bus sequencer

  // every strobe level is held a whole cycle, far above the glitch filter
  always_comb begin
    state_nxt   = state_r;
    cnt_nxt     = cntZero ? cnt_r : cnt_r - 1'b1;
    byteSel_nxt = byteSel_r;
    ready_nxt   = 1'b0;
    rspV_nxt    = 1'b0;
    rspD_nxt    = rspD_r;
    ceN_nxt     = ceN_r;
    oeN_nxt     = oeN_r;
    weN_nxt     = weN_r;
    rstN_nxt    = rstN_r;
    addr_nxt    = addr_r;
    dqOut_nxt   = dqOut_r;
    dqOeN_nxt   = dqOeN_r;
    unique case (state_r)
      ST_RSTLOW: begin
        if (cntZero) begin
          rstN_nxt  = 1'b1;
          cnt_nxt   = CNT_W'(REC_CYC - 1);
          state_nxt = ST_RECOVER;
        end
      end
      ST_RECOVER: begin
        // no access until both recovery delays have run out R12
        if (cntZero) begin
          ready_nxt = 1'b1;
          state_nxt = ST_IDLE;
        end
      end
      ST_IDLE: begin
        ready_nxt   = 1'b1;
        byteSel_nxt = byteMode;
        dqOeN_nxt   = byteMode ? 16'h7fff : 16'hffff;
        if (take) begin
          ready_nxt = 1'b0;
          addr_nxt  = pin_addr(reqAddr, byteSel_r);
          if (reqWrite) begin
            // address and data set up with select still high R4
            dqOut_nxt = wrData;
            dqOeN_nxt = wrOeN;
            oeN_nxt   = 1'b1; // R7
            state_nxt = ST_WRLOW;
          end else begin
            // select and drive fall together, strobe stays high R3
            dqOut_nxt = rdData;
            ceN_nxt   = 1'b0;
            oeN_nxt   = 1'b0;
            cnt_nxt   = CNT_W'(RD_CYC - 1);
            state_nxt = ST_RDWAIT;
          end
        end
      end
      ST_RDWAIT: begin
        // full random access time, both address and select timed R19
        if (cntZero) begin
          rspV_nxt  = 1'b1;
          rspD_nxt  = rdWord;
          ceN_nxt   = 1'b1;
          oeN_nxt   = 1'b1;
          cnt_nxt   = CNT_W'(WE_HIGH_CYC - 1);
          state_nxt = ST_GAP;
        end
      end
      ST_WRLOW: begin
        // select and strobe fall on one edge, address already stable
        ceN_nxt   = 1'b0;
        weN_nxt   = 1'b0;
        oeN_nxt   = 1'b1; // R7
        cnt_nxt   = CNT_W'(WE_LOW_CYC - 1);
        state_nxt = ST_WRHOLD;
      end
      ST_WRHOLD: begin
        // both rise together; data held one more cycle past the edge
        if (cntZero && !weN_r) begin
          ceN_nxt = 1'b1;
          weN_nxt = 1'b1;
        end else if (weN_r) begin
          rspV_nxt  = 1'b1;
          dqOeN_nxt = idleOeN;
          cnt_nxt   = CNT_W'(WE_HIGH_CYC - 1);
          state_nxt = ST_GAP;
        end
      end
      ST_GAP: begin
        // select stays high between accesses, next one is a random read R19
        if (cntZero) begin
          ready_nxt = 1'b1;
          state_nxt = ST_IDLE;
        end
      end
      default: begin
        state_nxt = ST_IDLE;
      end
    endcase
  end

  ////////////////////////////////////////////////////////////////////////////
  // registers

  // reset holds the flash in its own reset for the full pulse
  always_ff @(posedge mclk) begin
    if (!resetn) begin
      state_r   <= ST_RSTLOW;
      cnt_r     <= CNT_W'(RST_PULSE_CYC - 1);
      byteSel_r <= 1'b0;
      byteN_r   <= 1'b1;
      ready_r   <= 1'b0;
      rspV_r    <= 1'b0;
      rspD_r    <= '0;
      ceN_r     <= 1'b1;
      oeN_r     <= 1'b1;
      weN_r     <= 1'b1;
      rstN_r    <= 1'b0;
      addr_r    <= '0;
      dqOut_r   <= '0;
      dqOeN_r   <= '1;
    end else begin
      state_r   <= state_nxt;
      cnt_r     <= cnt_nxt;
      byteSel_r <= byteSel_nxt;
      byteN_r   <= ~byteSel_nxt; // width pin straight from a flop
      ready_r   <= ready_nxt;
      rspV_r    <= rspV_nxt;
      rspD_r    <= rspD_nxt;
      ceN_r     <= ceN_nxt;
      oeN_r     <= oeN_nxt;
      weN_r     <= weN_nxt;
      rstN_r    <= rstN_nxt;
      addr_r    <= addr_nxt;
      dqOut_r   <= dqOut_nxt;
      dqOeN_r   <= dqOeN_nxt;
    end
  end

  // protect level and busy flag follow their sources each cycle
  always_ff @(posedge mclk) begin
    if (!resetn) begin
      wpN_r  <= 1'b0;
      busy_r <= 1'b0;
    end else begin
      wpN_r  <= ~protectOn;
      // a flash held in reset is never busy; this also hides the
      // synchroniser's reset zero, which would read as a false busy
      busy_r <= rstN_r & ~flagNSync; // open-drain low means program/erase running
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // outputs, all from flops

  assign reqReady   = ready_r;
  assign rspValid   = rspV_r;
  assign rspData    = rspD_r;
  assign deviceBusy = busy_r;
  assign flashCeN   = ceN_r;
  assign flashOeN   = oeN_r;
  assign flashWeN   = weN_r;
  assign flashRstN  = rstN_r;
  assign flashWpN   = wpN_r;
  assign flashByteN = byteN_r;
  assign flashAddr  = addr_r;
  assign flashDqOut = dqOut_r;
  assign flashDqOeN = dqOeN_r;

endmodule : fbi_host_ctrl
`default_nettype wire

// ==== hw/fbi_pkg.sv ====
// constants shared by the flash bus host controller
// Behaviour
// R1 - array is uniform 128KB / 64KW blocks
// R2 - block count 128 to 1024 by density
// R3 - read: select low, drive low, strobe high
// R4 - write: select low, strobe low, drive high
// R5 - address captured at later falling edge
// R6 - data captured at earlier rising edge
// R7 - host keeps output drive high during writes
// R8 - select high in read gives standby
// R9 - no standby while program or erase runs
// R10 - drive high releases data pins
// R11 - reset low deselects, outputs high impedance
// R12 - host waits recovery delays after reset release
// R13 - after recovery device is in read array
// R14 - reset low aborts running program or erase
// R15 - pulses under 3ns on strobes are ignored
// R16 - protect pin low guards top/bottom block
// R17 - page read of 16 words, 32 bytes
// R18 - page reads also in extended and CFI areas
// R19 - reselect between accesses means random read timing
// R20 - width select low is byte mode
// R21 - byte mode top data pin is address LSB
// R22 - completion flag low while program/erase runs
package fbi_pkg;

  localparam int CLK_PERIOD_NS     = 25;
  localparam int RST_PULSE_NS      = 500;     // reset low pulse width
  localparam int RST_READ_REC_NS   = 50000;   // reset_to_read_recovery
  localparam int RST_WRITE_REC_NS  = 50000;   // reset_to_write_recovery
  localparam int ADDR_ACCESS_NS    = 100;     // address_access_time
  localparam int SELECT_ACCESS_NS  = 100;     // select_access_time
  localparam int WE_LOW_NS         = 35;      // strobe low width
  localparam int WE_HIGH_NS        = 20;      // strobe high / reselect gap

  localparam int ADDR_W            = 26;      // word address pins
  localparam int BADDR_W           = 27;      // byte address incl. low bit
  localparam int DATA_W            = 16;
  localparam int CNT_W             = 12;
  localparam int SYNC_STAGES       = 2;
  localparam int BLOCK_WORDS_LOG2  = 16;      // 64KW per block
  localparam int MAX_BLOCKS        = 1024;
  localparam int PAGE_WORDS_LOG2   = 4;       // 16-word page

  // least times round up, never below one cycle
  function automatic int cyc_up(input int ns);
    int c;
    c = (ns + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    return (c < 1) ? 1 : c;
  endfunction : cyc_up

  localparam int RST_PULSE_CYC  = cyc_up(RST_PULSE_NS);
  localparam int RD_REC_CYC     = cyc_up(RST_READ_REC_NS);
  localparam int WR_REC_CYC     = cyc_up(RST_WRITE_REC_NS);
  localparam int REC_CYC        = (RD_REC_CYC > WR_REC_CYC) ? RD_REC_CYC : WR_REC_CYC;
  localparam int ACC_CYC        = (cyc_up(ADDR_ACCESS_NS) > cyc_up(SELECT_ACCESS_NS)) ?
                                  cyc_up(ADDR_ACCESS_NS) : cyc_up(SELECT_ACCESS_NS);
  localparam int RD_CYC         = ACC_CYC + SYNC_STAGES + 1;
  localparam int WE_LOW_CYC     = cyc_up(WE_LOW_NS);
  localparam int WE_HIGH_CYC    = cyc_up(WE_HIGH_NS);

  typedef enum logic [2:0] {
    ST_RSTLOW  = 3'h0,
    ST_RECOVER = 3'h1,
    ST_IDLE    = 3'h2,
    ST_RDWAIT  = 3'h3,
    ST_WRLOW   = 3'h4,
    ST_WRHOLD  = 3'h5,
    ST_GAP     = 3'h6
  } fbi_state_t;

endpackage : fbi_pkg

// ==== hw/fbi_sync.sv ====
// two-stage synchroniser for pin inputs
`timescale 1ns/1ps
`default_nettype none
module fbi_sync #(
  parameter int W = 1
) (
  input  wire logic         mclk,
  input  wire logic         resetn,
  input  wire logic [W-1:0] din,
  output var  logic [W-1:0] dout
);

  logic [W-1:0] meta_r;

  // first stage feeds only the second stage
  always_ff @(posedge mclk) begin
    if (!resetn) begin
      meta_r <= '0;
      dout   <= '0;
    end else begin
      meta_r <= din;
      dout   <= meta_r;
    end
  end

endmodule : fbi_sync
`default_nettype wire

// ==== tb/fbi_chk.sv ====
// assertions on the host controller flash pins
`timescale 1ns/1ps
`default_nettype none
module fbi_chk
  import fbi_pkg::*;
(
  input wire logic              mclk,
  input wire logic              resetn,
  input wire logic              protectOn,
  input wire logic              byteMode,
  input wire logic              deviceBusy,
  input wire logic              flashCeN,
  input wire logic              flashOeN,
  input wire logic              flashWeN,
  input wire logic              flashRstN,
  input wire logic              flashWpN,
  input wire logic              flashByteN,
  input wire logic [DATA_W-1:0] flashDqOut,
  input wire logic [DATA_W-1:0] flashDqOeN,
  input wire logic              completionFlagNIn
);
  default clocking @(posedge mclk); endclocking
  default disable iff (!resetn);
  logic [CNT_W-1:0] upCnt_r;
  ////////////////////////////////////////
  // cycles since flash reset release, saturating so it never wraps
  always_ff @(posedge mclk) begin
    if (!flashRstN) upCnt_r <= '0;
    else if (upCnt_r != '1) upCnt_r <= upCnt_r + 1'b1;
  end
  // strobe steps of a read and of a write
  sequence s_rdOpen; $fell(flashCeN) && !flashOeN; endsequence
  sequence s_wrOpen; $fell(flashWeN) && $fell(flashCeN); endsequence
  sequence s_wrClose; $rose(flashWeN) && $rose(flashCeN); endsequence
  property p_rdHold; s_rdOpen |-> (!flashCeN && !flashOeN)[*4]; endproperty
  property p_wrPair; $fell(flashWeN) |-> s_wrOpen ##2 s_wrClose; endproperty
  property p_wrOe; !flashWeN |-> flashOeN && flashRstN; endproperty
  property p_rdPins; !flashOeN |-> !flashCeN && flashWeN && (&flashDqOeN[14:0]); endproperty
  property p_wrData; !flashWeN |-> flashDqOeN[7:0] == 8'h00 && $stable(flashDqOut); endproperty
  property p_rstIdle; !flashRstN |-> flashCeN && flashOeN && flashWeN; endproperty
  property p_recover; !flashCeN |-> upCnt_r >= REC_CYC; endproperty
  property p_wp; $past(resetn) |-> flashWpN == !$past(protectOn); endproperty
  property p_byte; !flashCeN |-> flashByteN == !byteMode && (flashByteN || !flashDqOeN[15]); endproperty
  property p_busy; $fell(completionFlagNIn) |-> ##[1:4] deviceBusy; endproperty
  a_rdHold: assert property (p_rdHold) else $error("read select too short");
  a_wrPair: assert property (p_wrPair) else $error("write strobes misaligned");
  a_wrOe: assert property (p_wrOe) else $error("output drive low in write");
  a_rdPins: assert property (p_rdPins) else $error("bad read pins");
  a_wrData: assert property (p_wrData) else $error("write data moved");
  a_rstIdle: assert property (p_rstIdle) else $error("strobe in reset");
  a_recover: assert property (p_recover) else $error("access in recovery");
  a_wp: assert property (p_wp) else $error("protect pin wrong");
  a_byte: assert property (p_byte) else $error("width pin wrong");
  a_busy: assert property (p_busy) else $error("busy not seen");
endmodule : fbi_chk
bind fbi_host_ctrl fbi_chk chk (.mclk, .resetn, .protectOn, .byteMode, .deviceBusy,
  .flashCeN, .flashOeN, .flashWeN, .flashRstN, .flashWpN, .flashByteN, .flashDqOut,
  .flashDqOeN, .completionFlagNIn);
`default_nettype wire

// ==== tb/fbi_flash_model.sv ====
// behavioural flash device on the far side of the controller
`timescale 1ns/1ps
`default_nettype none
module fbi_flash_model
  import fbi_pkg::*;
(
  input  wire logic              mclk,
  input  wire logic              ceN,
  input  wire logic              oeN,
  input  wire logic              weN,
  input  wire logic              rstN,
  input  wire logic              byteN,
  input  wire logic [ADDR_W-1:0] addr,
  input  wire logic [DATA_W-1:0] dqOut,
  input  wire logic [DATA_W-1:0] dqOeN,
  output var  logic [DATA_W-1:0] dqBus,
  output var  logic              readyN
);
  logic [BADDR_W-1:0] fullAddr, cmdAddr;
  logic [DATA_W-1:0]  rdData, devEn, cmdData;
  logic [DATA_W-1:0]  junk = 16'h5a3c;
  logic               wrOpen = 1'b0;
  logic [9:0]         cmdBlk;
  int                 busyLeft = 0;
  ////////////////////////////////////////
  // byte mode takes the top data pin as address lsb
  assign fullAddr = byteN ? {1'b0, addr} : {addr, dqOut[15]};
  // same read path serves array, extended and cfi areas
  assign rdData = byteN ? addr[15:0] ^ 16'hc3a5
                        : {8'h00, fullAddr[7:0] ^ fullAddr[15:8]};
  // block of the last command: 64KW in word mode, 128KB in byte mode
  assign cmdBlk = byteN ? cmdAddr[ADDR_W-1:BLOCK_WORDS_LOG2]
                        : cmdAddr[BADDR_W-1:BLOCK_WORDS_LOG2+1];
  // only a selected read drives; upper lanes stay off in byte mode
  assign devEn = {16{!ceN && !oeN && weN && rstN}} & (byteN ? 16'hffff : 16'h00ff);
  // undriven bits wander so a stale value never passes
  assign dqBus = (devEn & rdData) | (~devEn & ~dqOeN & dqOut) | (~devEn & dqOeN & junk);
  assign readyN = (busyLeft == 0);
  always @(posedge mclk) junk <= ~junk;
  // address at the later falling edge, data at the earlier rising edge
  always @(negedge ceN or negedge weN) begin
    if (!ceN && !weN && rstN) begin
      cmdAddr = fullAddr;
      wrOpen = 1'b1;
    end
  end
  always @(posedge ceN or posedge weN) begin
    if (wrOpen) begin
      cmdData = dqBus;
      wrOpen = 1'b0;
      busyLeft = 10;
    end
  end
  // a program runs on through deselect; reset aborts it
  always @(posedge mclk) begin
    if (!rstN) busyLeft <= 0;
    else if (busyLeft != 0) busyLeft <= busyLeft - 1;
  end
endmodule : fbi_flash_model
`default_nettype wire

// ==== tb/fbi_host_ctrl_test.sv ====
// self-checking bench for the flash bus host controller
`timescale 1ns/1ps
`default_nettype none
module fbi_host_ctrl_test
  import fbi_pkg::*;
;
  logic               mclk = 1'b0, resetn = 1'b0, reqValid = 1'b0, reqWrite = 1'b0;
  logic               byteMode = 1'b0, protectOn = 1'b0;
  logic [BADDR_W-1:0] reqAddr = '0;
  logic [DATA_W-1:0]  reqWdata = '0, rspData, dqBus, flashDqOut, flashDqOeN;
  logic               reqReady, rspValid, deviceBusy, readyN, flashCeN, flashOeN, flashWeN;
  logic               flashRstN, flashWpN, flashByteN;
  logic [ADDR_W-1:0]  flashAddr;
  int                 errorCnt = 0, checkCount = 0, seed = 32'hfdca;
  fbi_host_ctrl uut (.mclk, .resetn, .reqValid, .reqWrite, .reqAddr, .reqWdata, .byteMode,
    .protectOn, .reqReady, .rspValid, .rspData, .deviceBusy, .flashCeN, .flashOeN, .flashWeN,
    .flashRstN, .flashWpN, .flashByteN, .flashAddr, .flashDqIn(dqBus), .flashDqOut,
    .flashDqOeN, .completionFlagNIn(readyN));
  fbi_flash_model model (.mclk, .ceN(flashCeN), .oeN(flashOeN), .weN(flashWeN),
    .rstN(flashRstN), .byteN(flashByteN), .addr(flashAddr), .dqOut(flashDqOut),
    .dqOeN(flashDqOeN), .dqBus, .readyN);
  ////////////////////////////////////////
  initial forever #12.5 mclk = ~mclk;
  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    checkCount++;
    if (seen !== exp) begin
      errorCnt++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
    end
  endtask : check
  task automatic give_verdict;
    $display("checks %0d errors %0d", checkCount, errorCnt);
    if (errorCnt == 0 && checkCount > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask : give_verdict
  function automatic logic [DATA_W-1:0] expRd(input logic [BADDR_W-1:0] a, input logic bm);
    return bm ? {8'h00, a[7:0] ^ a[15:8]} : a[15:0] ^ 16'hc3a5;
  endfunction : expRd
  // ready only after the reset pulse and the recovery wait
  task automatic do_reset;
    int n;
    @(posedge mclk);
    resetn <= 1'b0;
    repeat (20) @(posedge mclk);
    @(negedge mclk);
    check("pinsInReset", {flashRstN, flashCeN, flashWeN}, 3'b011);
    check("flagReleased", readyN, 1'b1);
    @(posedge mclk);
    resetn <= 1'b1;
    n = 0;
    do begin @(negedge mclk); n++; end while (!reqReady && n < 5000);
    check("recovery", n >= RST_PULSE_CYC + REC_CYC, 1);
  endtask : do_reset
  task automatic xfer(input logic wr, input logic bm, input logic [BADDR_W-1:0] a,
                      input logic [DATA_W-1:0] d);
    int n;
    logic [BADDR_W-1:0] fa;
    fa = bm ? a : {1'b0, a[ADDR_W-1:0]};
    @(posedge mclk);
    byteMode <= bm;
    protectOn <= $random(seed);
    @(posedge mclk);
    reqValid <= 1'b1;
    reqWrite <= wr;
    reqAddr <= fa;
    reqWdata <= d;
    n = 0;
    do begin @(negedge mclk); n++; end while (!reqReady && n < 50);
    @(posedge mclk);
    reqValid <= 1'b0;
    n = 0;
    do begin @(negedge mclk); n++; end while (rspValid !== 1'b1 && n < 40);
    check("latency", n, wr ? WE_LOW_CYC + 3 : RD_CYC + 1);
    check("protectPin", flashWpN, !protectOn);
    if (wr) begin
      check("cmdAddr", model.cmdAddr, fa);
      check("cmdData", bm ? model.cmdData[7:0] : model.cmdData, bm ? d[7:0] : d);
      repeat (3) @(negedge mclk);
      check("busy", deviceBusy, 1'b1);
    end else begin
      check("rdData", rspData, expRd(fa, bm));
    end
  endtask : xfer
  // corners first: highest byte address, lowest word address, top block in both widths, then random traffic
  initial begin
    do_reset();
    xfer(1'b0, 1'b1, '1, 16'h0000);
    xfer(1'b0, 1'b0, '0, 16'h0000);
    xfer(1'b1, 1'b1, '1, 16'h00a5);
    check("topBlockByte", model.cmdBlk, MAX_BLOCKS - 1);
    xfer(1'b1, 1'b0, 27'h3ff0000, 16'hffff);
    check("topBlockWord", model.cmdBlk, MAX_BLOCKS - 1);
    repeat (24) xfer($random(seed), $random(seed), $random(seed), $random(seed));
    // reset in the middle of a running program
    xfer(1'b1, 1'b0, 27'h0012345, 16'h1234);
    do_reset();
    check("abortBusy", deviceBusy, 1'b0);
    xfer(1'b0, 1'b0, 27'h0000155, 16'h0000);
    give_verdict();
  end
  // cut a hang short well beyond the expected run
  initial begin
    #(CLK_PERIOD_NS * 20000);
    errorCnt++;
    give_verdict();
  end
endmodule : fbi_host_ctrl_test
`default_nettype wire
